// ===== inc/vt_pkg.sv
`default_nettype none
package vt_pkg;
    localparam int W = 16;
    typedef logic signed [W-1:0] q15_t;
    typedef struct packed { q15_t a; q15_t b; q15_t c; } phase_t;
    typedef struct packed { q15_t al; q15_t be; } ab_t;
    typedef struct packed { q15_t d; q15_t q; } dq_t;
    typedef enum logic [3:0] {S_IDLE, S_CLARKE, S_FLUX, S_ROOT, S_DIV, S_PARK, S_IPARK, S_ICLARKE, S_DONE} state_t;
    // q15 fixed-point constants
    localparam int FRAC = 15;
    localparam q15_t Q_MAX = 16'sh7FFF;
    localparam q15_t Q_MIN = -16'sh7FFF;
    localparam q15_t K_HALF = 16'sh4000;
    localparam q15_t K_SQRT3_2 = 16'sh6EDA;
    localparam q15_t K_INV_SQRT3 = 16'sh49E7;
    localparam q15_t K_THIRD = 16'sh2AAB;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int DEAD_NS = 500;
    localparam int DEAD_CYC = (DEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ROOT_BITS = 15;
    localparam int PASS_CYC = 23;
endpackage
`default_nettype wire

// ===== rtl/vector_transform.sv
`timescale 1ns/1ps
`default_nettype none
module vector_transform #(
    parameter vt_pkg::q15_t K_U     = 16'sh2000,
    parameter vt_pkg::q15_t K_WTR   = 16'sh1000,
    parameter vt_pkg::q15_t K_DI    = 16'sh0800,
    parameter vt_pkg::q15_t K_DT    = 16'sh0100,
    parameter int           CAR_STEP = 16
) (
    input  wire logic          CLK_I,
    input  wire logic          SRST_I,
    input  wire logic          SAMPLE_I,
    input  wire logic          TWO_PHASE_I,
    input  wire vt_pkg::phase_t I_PH_I,
    input  wire vt_pkg::ab_t   U_AB_I,
    input  wire vt_pkg::q15_t  SPEED_I,
    input  wire vt_pkg::dq_t   U_DQ_I,
    output logic               BUSY_O,
    output logic               DONE_O,
    output vt_pkg::dq_t        I_DQ_O,
    output vt_pkg::q15_t       FLUX_O,
    output vt_pkg::ab_t        SINCOS_O,
    output vt_pkg::ab_t        U_AB_O,
    output vt_pkg::phase_t     U_PH_O,
    output logic [2:0]         GATE_HI_O,
    output logic [2:0]         GATE_LO_O
);
    import vt_pkg::*;

    if (CAR_STEP < 1 || CAR_STEP > 4096)
    begin : g_bad_step
        $error("CAR_STEP out of range");
    end

    // saturate rather than wrap
    function automatic q15_t sat(input logic signed [47:0] x);
        if (x > 48'sh7FFF)
            return Q_MAX;
        else if (x < -48'sh7FFF)
            return Q_MIN;
        else
            return x[W-1:0];
    endfunction

    function automatic q15_t mulq(input logic signed [31:0] x, input q15_t k);
        logic signed [47:0] p;
        p = 48'(x) * 48'(k);
        return sat(p >>> FRAC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    state_t st_q, st_d;
    phase_t ph_q, uph_q;
    ab_t    iab_q, uab_q, uin_q, psi_q, iprev_q, sc_q;
    dq_t    idq_q, udq_q;
    q15_t   w_q, flux_q;
    logic   two_q, done_q;
    logic [3:0] bit_q;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            S_IDLE:    st_d = SAMPLE_I ? S_CLARKE : S_IDLE;
            S_CLARKE:  st_d = S_FLUX;
            S_FLUX:    st_d = S_ROOT;
            S_ROOT:    st_d = (bit_q == 4'h0) ? S_DIV : S_ROOT;
            S_DIV:     st_d = S_PARK;
            S_PARK:    st_d = S_IPARK;
            S_IPARK:   st_d = S_ICLARKE;
            S_ICLARKE: st_d = S_DONE;
            S_DONE:    st_d = S_IDLE;
            default:   st_d = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // forward clarke, alpha along phase a
    wire logic signed [31:0] al3 = 32'(ph_q.a) * 2 - 32'(ph_q.b) - 32'(ph_q.c);
    wire logic signed [31:0] be3 = 32'(ph_q.b) - 32'(ph_q.c);
    wire logic signed [31:0] be2 = 32'(ph_q.a) + 32'(ph_q.b) * 2;
    wire q15_t clk_al = two_q ? ph_q.a : mulq(al3, K_THIRD);
    wire q15_t clk_be = two_q ? mulq(be2, K_INV_SQRT3) : mulq(be3, K_INV_SQRT3);

    // stationary-frame flux model; speed cross terms couple the axes
    wire logic signed [31:0] dia = 32'(iab_q.al) - 32'(iprev_q.al);
    wire logic signed [31:0] dib = 32'(iab_q.be) - 32'(iprev_q.be);
    wire q15_t wpa = mulq(32'(w_q), psi_q.al);
    wire q15_t wpb = mulq(32'(w_q), psi_q.be);
    wire logic signed [31:0] acc_a = 32'(mulq(32'(uin_q.al), K_U)) - 32'(psi_q.al)
                                   - 32'(mulq(32'(wpb), K_WTR)) - 32'(mulq(dia, K_DI));
    wire logic signed [31:0] acc_b = 32'(mulq(32'(uin_q.be), K_U)) + 32'(mulq(32'(wpa), K_WTR))
                                   - 32'(psi_q.be) - 32'(mulq(dib, K_DI));
    wire q15_t psa_d = sat(48'(psi_q.al) + 48'(mulq(acc_a, K_DT)));
    wire q15_t psb_d = sat(48'(psi_q.be) + 48'(mulq(acc_b, K_DT)));

    // magnitude by bit-serial square root; one result bit per cycle
    wire logic [31:0] rad = 32'(32'(psi_q.al) * 32'(psi_q.al)) + 32'(32'(psi_q.be) * 32'(psi_q.be));
    wire logic [15:0] trial = 16'(flux_q) | (16'h0001 << bit_q);
    // squares of q15 values are compared unscaled, so the root comes out in q15 as well
    wire logic        keep = (32'(trial) * 32'(trial)) <= rad;

    // angle by division, no trig tables; zero flux falls back to angle zero
    wire logic signed [31:0] div_s = (flux_q == 16'sh0000) ? 32'sh0 :
                                     (32'(psi_q.be) <<< FRAC) / 32'(flux_q);
    wire logic signed [31:0] div_c = (flux_q == 16'sh0000) ? 32'(Q_MAX) :
                                     (32'(psi_q.al) <<< FRAC) / 32'(flux_q);

    // park
    wire q15_t pk_d = sat(48'(mulq(32'(iab_q.al), sc_q.be)) + 48'(mulq(32'(iab_q.be), sc_q.al)));
    wire q15_t pk_q = sat(48'(mulq(32'(iab_q.be), sc_q.be)) - 48'(mulq(32'(iab_q.al), sc_q.al)));
    // inverse park
    wire q15_t ip_a = sat(48'(mulq(32'(udq_q.d), sc_q.be)) - 48'(mulq(32'(udq_q.q), sc_q.al)));
    wire q15_t ip_b = sat(48'(mulq(32'(udq_q.d), sc_q.al)) + 48'(mulq(32'(udq_q.q), sc_q.be)));
    // inverse clarke, 120 degree spacing falls out of the matrix
    wire q15_t hal = mulq(32'(uab_q.al), K_HALF);
    wire q15_t rbe = mulq(32'(uab_q.be), K_SQRT3_2);
    wire q15_t ic_b = sat(48'(rbe) - 48'(hal));
    wire q15_t ic_c = sat(-48'(hal) - 48'(rbe));

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            st_q    <= S_IDLE;
            ph_q    <= '0;
            uin_q   <= '0;
            w_q     <= '0;
            two_q   <= 1'b0;
            iab_q   <= '0;
            iprev_q <= '0;
            psi_q   <= '0;
            flux_q  <= '0;
            bit_q   <= '0;
            sc_q    <= '0;
            idq_q   <= '0;
            udq_q   <= '0;
            uab_q   <= '0;
            uph_q   <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            done_q <= (st_q == S_DONE);
            case (st_q)
                S_IDLE:
                if (SAMPLE_I)
                begin
                    ph_q  <= I_PH_I;
                    uin_q <= U_AB_I;
                    w_q   <= SPEED_I;
                    two_q <= TWO_PHASE_I;
                end
                S_CLARKE:
                begin
                    iprev_q <= iab_q;
                    iab_q   <= '{al: clk_al, be: clk_be};
                end
                S_FLUX:
                begin
                    psi_q  <= '{al: psa_d, be: psb_d};
                    flux_q <= '0;
                    bit_q  <= 4'(ROOT_BITS - 1);
                end
                S_ROOT:
                begin
                    flux_q <= keep ? q15_t'(trial) : flux_q;
                    bit_q  <= bit_q - 4'h1;
                end
                S_DIV:     sc_q  <= '{al: sat(48'(div_s)), be: sat(48'(div_c))};
                S_PARK:
                begin
                    idq_q <= '{d: pk_d, q: pk_q};
                    udq_q <= U_DQ_I;
                end
                S_IPARK:   uab_q <= '{al: ip_a, be: ip_b};
                S_ICLARKE: uph_q <= '{a: uab_q.al, b: ic_b, c: ic_c};
                default:   ;
            endcase
        end
    end

    // only the flux modulus leaves; the alpha and beta flux components in psi_q stay internal
    assign FLUX_O   = flux_q;
    assign SINCOS_O = sc_q;
    assign I_DQ_O   = idq_q;
    assign U_AB_O   = uab_q;
    assign U_PH_O   = uph_q;
    assign DONE_O   = done_q;
    assign BUSY_O   = (st_q != S_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // symmetric triangle carrier
    localparam logic signed [16:0] STEP = 17'(CAR_STEP);
    logic signed [16:0] tri_q;
    logic               up_q;
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            tri_q <= '0;
            up_q  <= 1'b1;
        end
        else
        begin
            tri_q <= up_q ? tri_q + STEP : tri_q - STEP;
            if (up_q && tri_q + STEP >= 17'(Q_MAX))
                up_q <= 1'b0;
            else if (!up_q && tri_q - STEP <= 17'(Q_MIN))
                up_q <= 1'b1;
        end
    end

    localparam int DW = $clog2(DEAD_CYC + 1);
    logic [2:0] cmp, lvl_q, hi_q, lo_q, arm_q;
    logic [DW-1:0] dcnt_q [3];
    for (genvar p = 0; p < 3; p++)
    begin : g_leg
        // references only change at pass end, so a leg sees one step per sample
        // the reference is signed; a plain part-select would push negative values above the carrier
        assign cmp[p] = 17'($signed(uph_q[(2-p)*W +: W])) > tri_q;
        always_ff @(posedge CLK_I)
        begin
            if (SRST_I)
            begin
                lvl_q[p]  <= 1'b0;
                arm_q[p]  <= 1'b0;
                dcnt_q[p] <= '0;
                hi_q[p]   <= 1'b0;
                lo_q[p]   <= 1'b0;
            end
            else
            begin
                // the gate on before a reset is unknown, so both stay off one dead time first
                if (!arm_q[p])
                begin
                    if (dcnt_q[p] == DW'(DEAD_CYC - 1))
                    begin
                        arm_q[p]  <= 1'b1;
                        lvl_q[p]  <= cmp[p];
                        dcnt_q[p] <= '0;
                    end
                    else
                        dcnt_q[p] <= dcnt_q[p] + 1'b1;
                end
                // a crossing shorter than the dead time is swallowed
                else if (cmp[p] == lvl_q[p])
                    dcnt_q[p] <= '0;
                else if (dcnt_q[p] == DW'(DEAD_CYC - 1))
                begin
                    lvl_q[p]  <= cmp[p];
                    dcnt_q[p] <= '0;
                end
                else
                    dcnt_q[p] <= dcnt_q[p] + 1'b1;
                hi_q[p] <= arm_q[p] & (cmp[p] == lvl_q[p]) & lvl_q[p];
                lo_q[p] <= arm_q[p] & (cmp[p] == lvl_q[p]) & ~lvl_q[p];
            end
        end
    end
    assign GATE_HI_O = hi_q;
    assign GATE_LO_O = lo_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    a_gates_never_both: assert property ((hi_q & lo_q) == 3'b000)
        else $error("both gates of a leg on");
    a_dead_gap_lo: assert property ($rose(lo_q[0]) |-> !$past(hi_q[0], DEAD_CYC))
        else $error("low gate on inside dead time");
    a_dead_gap_hi: assert property ($fell(lo_q[1]) |-> !hi_q[1] [*8])
        else $error("high gate on too soon");
    a_gate_follows_cmp: assert property (hi_q[2] |-> $past(cmp[2]))
        else $error("high gate against carrier compare");
    a_two_phase_alpha: assert property ((st_q == S_FLUX && two_q) |-> iab_q.al == ph_q.a)
        else $error("two-phase alpha differs from phase a");
    a_root_bound: assert property ((st_q == S_DIV) |-> 32'(flux_q) * 32'(flux_q) <= rad)
        else $error("flux root too large");
    a_pass_latency: assert property ((st_q == S_IDLE && SAMPLE_I) |=> !DONE_O [*8] ##15 DONE_O)
        else $error("pass did not complete in time");
    a_done_single: assert property (DONE_O |-> st_q == S_IDLE ##1 !DONE_O)
        else $error("done longer than one cycle");
    a_phase_sum: assert property (DONE_O |-> (48'(U_PH_O.a) + 48'(U_PH_O.b) + 48'(U_PH_O.c) <= 48'sd3
                                  && 48'(U_PH_O.a) + 48'(U_PH_O.b) + 48'(U_PH_O.c) >= -48'sd3)
                                  || uab_q.be > 16'sh6000 || uab_q.be < -16'sh6000)
        else $error("phase references not balanced");
    a_no_wrap: assert property (U_AB_O.al != 16'sh8000 && U_AB_O.be != 16'sh8000)
        else $error("alpha-beta output wrapped");

    c_pass_done: cover property (DONE_O);
    c_two_phase: cover property (st_q == S_CLARKE && two_q);
    c_dead_time: cover property ($fell(hi_q[0]) ##[1:200] $rose(lo_q[0]));
endmodule
`default_nettype wire

// ===== sim/inverter_model.sv
`timescale 1ns/1ps
`default_nettype none
module inverter_model
    import vt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  hi_i,
    input  wire logic [2:0]  lo_i,
    input  wire logic        clr_i,
    input  wire phase_t      load_i,
    output phase_t           sense_o,
    output logic             fault_o,
    output logic [2:0][15:0] hi_cnt_o
);
    // start values stand for a long idle before power-up; a reset does not clear them,
    // so a partner gate turned on soon after a mid-run reset still counts as a fault
    logic [2:0][7:0] gap_q  = '1;
    logic [2:0]      side_q = '0;
    ////////////////////////////////////////////////////////////////////////////
    // sensing lags the load by one clock; gap counts saturate so idle never wraps
    // only the partner gate needs the dead gap; the same gate may come back at once
    always @(posedge clk_i)
    begin
        sense_o <= load_i;
        fault_o <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            if (hi_i[i] && lo_i[i])
                fault_o <= 1'b1;
            if (((hi_i[i] && !side_q[i]) || (lo_i[i] && side_q[i])) && gap_q[i] < DEAD_CYC)
                fault_o <= 1'b1;
            if (hi_i[i])
                side_q[i] <= 1'b1;
            else if (lo_i[i])
                side_q[i] <= 1'b0;
            gap_q[i] <= (hi_i[i] || lo_i[i]) ? 8'h00 : gap_q[i] + {7'h00, gap_q[i] != 8'hFF};
            hi_cnt_o[i] <= clr_i ? 16'h0000 : hi_cnt_o[i] + {15'h0000, hi_i[i]};
        end
        if (rst_i)
            hi_cnt_o <= '0;
    end
endmodule
`default_nettype wire

// ===== sim/induction_motor_vector_transform_bench.sv
`timescale 1ns/1ps
`default_nettype none
module induction_motor_vector_transform_bench;
    import vt_pkg::*;
    typedef struct { bit x; int t; longint e[5]; } note_t;
    logic             clk = 1'b0, srst = 1'b1, sample = 1'b0, two = 1'b0, clr = 1'b0;
    logic             busy, done, fault;
    phase_t           load = '0, iph, uph;
    ab_t              uab = '0, uabo, sc;
    dq_t              udq = '0, idq;
    q15_t             speed = '0, flux;
    logic [2:0]       ghi, glo;
    logic [2:0][15:0] hic;
    int               mismatches = 0, cmp_count = 0, cyc = 0, seed = 32'h3487;
    note_t            notes[$];
    note_t            n;
    always #2.5 clk = ~clk;
    // no current-derivative gain: flux stays zero until a stator voltage is applied;
    // full voltage gain and step make the flux follow the voltage, large enough for a precise angle
    vector_transform #(.K_U(16'sh7FFF), .K_DI(16'sh0000), .K_DT(16'sh7FFF), .CAR_STEP(64))
        u_dut (.CLK_I(clk), .SRST_I(srst), .SAMPLE_I(sample),
        .TWO_PHASE_I(two), .I_PH_I(iph), .U_AB_I(uab), .SPEED_I(speed), .U_DQ_I(udq), .BUSY_O(busy),
        .DONE_O(done), .I_DQ_O(idq), .FLUX_O(flux), .SINCOS_O(sc), .U_AB_O(uabo), .U_PH_O(uph),
        .GATE_HI_O(ghi), .GATE_LO_O(glo));
    inverter_model u_inv (.clk_i(clk), .rst_i(srst), .hi_i(ghi), .lo_i(glo), .clr_i(clr), .load_i(load),
        .sense_o(iph), .fault_o(fault), .hi_cnt_o(hic));
    ////////////////////////////////////////////////////////////////////////////
    function automatic longint sat(longint v);
        return v > 32767 ? 32767 : (v < -32767 ? -32767 : v);
    endfunction
    function automatic logic signed [63:0] n2(input logic signed [63:0] x, y);
        return x * x + y * y;
    endfunction
    function automatic q15_t rnd(int m);
        return q15_t'($random(seed) % m);
    endfunction
    task automatic check(input logic signed [63:0] seen, exp, tol);
        logic signed [63:0] df;
        df = seen - exp;
        cmp_count++;
        if ((df <= tol) !== 1'b1 || (df >= -tol) !== 1'b1)
        begin
            mismatches++;
            $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // exact notes assume zero flux: sin 0, cos full scale
    task automatic start(input bit x, input bit tp, input phase_t ld, input dq_t v);
        longint a, b, c, d, q, al, be;
        note_t  m;
        a = ld.a;
        b = ld.b;
        c = ld.c;
        d = v.d;
        q = v.q;
        al = sat(tp ? a : (2 * a - b - c) / 3);
        be = sat(tp ? (a + 2 * b) * 18919 / 32768 : (b - c) * 18919 / 32768);
        m.x = x;
        m.e = '{al, be, d, sat(-d / 2 + q * 28378 / 32768), sat(-d / 2 - q * 28378 / 32768)};
        if (!x)
            m.e[0] = al * al + be * be;
        if (!x)
            m.e[1] = 3 * (d * d + q * q) / 2;
        load <= ld;
        @(posedge clk);
        sample <= 1'b1;
        two <= tp;
        udq <= v;
        m.t = cyc;
        notes.push_back(m);
        @(posedge clk);
        sample <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 4 && srst === 1'b0)
            check(fault, 0, 0);
        if (done === 1'b1 && notes.size() == 0)
            check(1, 0, 0);
        else if (done === 1'b1)
        begin
            n = notes.pop_front();
            check(cyc - n.t, 22 + 2, 0);
            if (n.x)
            begin
                check(idq.d, n.e[0], 4);
                check(idq.q, n.e[1], 4);
                check(sc.al, 0, 0);
                check(sc.be, 32767, 0);
                check(uph.a, n.e[2], 4);
                check(uph.b, n.e[3], 4);
                check(uph.c, n.e[4], 4);
            end
            else
            begin
                check(n2(idq.d, idq.q), n.e[0], n.e[0] / 128 + 4096);
                check(n2(sc.al, sc.be), 1073676289, 8388608);
                check(n2(uph.a, uph.b) + n2(uph.c, 0), n.e[1], n.e[1] / 128 + 4096);
            end
        end
    end
    always @(posedge clk)
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            test_done;
        end
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        start(1, 0, '{16'sh7FFF, -16'sh7FFF, -16'sh7FFF}, '{-16'sh7FFF, 16'sh7FFF});
        repeat (21) @(posedge clk);
        start(1, 1, '{16'sh03E8, 16'sh07D0, 16'sh7FFF}, '{16'sh4000, 16'sh0000});
        repeat (21) @(posedge clk);
        start(1, 0, '{16'sh0BB8, -16'sh03E8, -16'sh07D0}, '{16'sh0000, -16'sh4E20});
        repeat (21) @(posedge clk);
        for (int i = 0; i < 6; i++)
        begin
            uab <= '{rnd(20000), rnd(20000)};
            speed <= rnd(8000);
            start(0, i[0], '{rnd(8000), rnd(8000), rnd(8000)}, '{rnd(8000), rnd(8000)});
            repeat (4) @(posedge clk);
            check(busy, 1, 0);
            sample <= 1'b1;
            load <= '{rnd(8000), rnd(8000), rnd(8000)};
            @(posedge clk);
            sample <= 1'b0;
            repeat (16) @(posedge clk);
        end
        repeat (30) @(posedge clk);
        check(notes.size(), 0, 0);
        srst <= 1'b1;
        uab <= '0;
        speed <= '0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        start(1, 0, '{16'sh4000, 16'shE000, 16'shE000}, '{16'sh4000, 16'sh0000});
        repeat (400) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (8192) @(posedge clk);
        check(hic[0], (16384 + 32767) * 8192 / 65534 - 4 * (DEAD_CYC + 1), 250);
        check(hic[1], (32767 - 8192) * 8192 / 65534 - 4 * (DEAD_CYC + 1), 250);
        check(hic[2], (32767 - 8192) * 8192 / 65534 - 4 * (DEAD_CYC + 1), 250);
        test_done;
    end
endmodule
`default_nettype wire
